// file: wakeup_power_state_controller_tb.sv
// Purpose: self-checking bench of the wake-up controller
// Assumes: short slow tick; straps held steady across each release
// Notes: read results checked in order from a queue
`timescale 1ns/10ps
module wakeup_power_state_controller_tb
  import wpsc_pkg::*;
;
  logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic strapLo, strapHi, rxCar, rxId, tGood, irq, irqReq, sysRstN, boot;
  logic [GPIO_WAKE_N-1:0] gpio;
  wpsc_mode_t mode;
  wpsc_pwr_t pw;
  logic [33:0] qe[$], qm[$];
  logic [1:0] qb[$];
  int errors, compares, p;
  wire logic [3:0] hs = {boot, rvalid, bvalid, arready};

  wpsc_wakeup_ctrl #(.TICK_CYCLES(4)) DUT (
    .mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .modeStrapLow(strapLo),
    .modeStrapHigh(strapHi), .gpioPin(gpio), .rxCarrierDet(rxCar),
    .rxIdMatch(rxId), .overtempGood(tGood), .periphIrq(irq),
    .sysResetN(sysRstN), .bootLoad(boot), .opMode(mode), .pwrCtl(pw)
  );
  wpsc_sys_partner u_cpu (
    .mclk(mclk), .resetn(resetn), .irqReq(irqReq),
    .cpuClkEn(pw.cpuClkEn), .periphIrq(irq)
  );

  ////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [33:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task end_sim;
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  // Sample at negedge, act after the next rising edge
  task waitHi(input int k);
    logic v;
    do begin
      @(negedge mclk);
      v = hs[k];
      @(posedge mclk);
    end while (v !== 1'b1);
  endtask : waitHi

  task wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = RESP_OKAY);
    logic ta, tw, ra, rw;
    qb.push_back(r);
    ta = 0;
    tw = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge mclk);
      ra = awready;
      rw = wready;
      @(posedge mclk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
      ta |= ra;
      tw |= rw;
    end while (!(ta && tw));
    waitHi(1);
    bready <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task rd(input logic [7:0] a, input logic [33:0] e, m);
    qe.push_back(e & m);
    qm.push_back(m);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    waitHi(0);
    arvalid <= 1'b0;
    waitHi(2);
    rready <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task st(input wpsc_state_t s);
    rd(REG_STATUS, {RESP_OKAY, 29'h0, s}, 34'h3_0000_0007);
  endtask : st

  always @(posedge mclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && qe.size() > 0) begin
      chk("rdata", {rresp, rdata} & qm.pop_front(), qe.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1 && qb.size() > 0) begin
      chk("bresp", 34'(bresp), 34'(qb.pop_front()));
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_sim;
  end

  initial begin
    void'($urandom(28));
    {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, rxCar, rxId, irqReq} = '0;
    {strapHi, strapLo, tGood, wstrb, gpio} = '1;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    waitHi(3);
    chk("mode", 34'(mode), 34'(MODE_NORMAL));
    chk("sysrst", 34'(sysRstN), 34'h1);
    rd(REG_CTRL, {RESP_OKAY, CTRL_RESET}, '1);
    rd(8'h20, {RESP_SLVERR, 32'h0}, '1);
    wr(8'h20, 32'h1, RESP_SLVERR);
    rd(REG_DUTY_CFG, {RESP_OKAY, DUTY_RESET}, '1);
    wr(REG_DUTY_CFG, 32'h0000_ff00);
    wr(REG_CTRL, 32'h60);
    repeat (100) @(posedge mclk);
    rd(REG_STATUS, {RESP_OKAY, 32'h1}, 34'h3_0000_0107);
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS, {RESP_OKAY, 32'h103}, 34'h3_0000_0107);
    chk("clk", 34'(pw.cpuClkEn), 34'h0);
    irqReq <= 1'b1;
    repeat (20) @(posedge mclk);
    st(ST_RUN);
    irqReq <= 1'b0;
    p = $urandom % GPIO_WAKE_N;
    wr(REG_CTRL, 32'h802 | (32'h1 << (CTRL_GPIO_EN_LSB + p)));
    gpio[p] <= 1'b0;
    repeat (20) @(posedge mclk);
    st(ST_PDWN);
    chk("pdwn", {28'h0, pw.cpuSupply, pw.regSupply, pw.iramSupply,
      pw.memSupply, pw.hfOscSupply, pw.xramActive}, 34'h0);
    wr(REG_CTRL, 32'h1 << (CTRL_GPIO_EN_LSB + p));
    waitHi(3);
    gpio <= '1;
    st(ST_RUN);
    tGood <= 1'b0;
    wr(REG_CTRL, 32'h8);
    wr(REG_CTRL, 32'ha);
    st(ST_SHDN);
    tGood <= 1'b1;
    waitHi(3);
    wr(REG_CTRL, 32'h2);
    rxCar <= 1'b1;
    waitHi(3);
    rxCar <= 1'b0;
    st(ST_RUN);
    {strapHi, strapLo} <= 2'b01;
    wr(REG_CTRL, 32'h4);
    waitHi(3);
    chk("mode", 34'(mode), 34'(MODE_NORMAL));
    wr(REG_WAKE_TIMER, 32'h3);
    waitHi(3);
    rd(REG_WAKE_TIMER, {RESP_OKAY, 32'hff00}, 34'h3_0000_ff00);
    rd(REG_WAKE_CAUSE, {RESP_OKAY, 32'h1b}, '1);
    wr(REG_WAKE_CAUSE, 32'h1b);
    rd(REG_WAKE_CAUSE, {RESP_OKAY, 32'h0}, '1);
    chk("mode", 34'(mode), 34'(MODE_NORMAL));
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    waitHi(3);
    chk("mode", 34'(mode), 34'(MODE_DEBUG));
    repeat (4) @(posedge mclk);
    end_sim;
  end
endmodule : wakeup_power_state_controller_tb

// file: wpsc_pkg.sv
// Purpose: constants and types of the wake-up and power-state controller
// Assumes: 50 MHz mclk; the 4 kHz oscillator is a tick derived from it
// Notes: registers are one aligned 32-bit word each on AXI4-Lite
package wpsc_pkg;

  // Clocking and derived tick counts
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int SLOW_OSC_HZ = 4000;
  localparam int SLOW_TICK_CYCLES = SYS_CLK_HZ / SLOW_OSC_HZ;
  localparam int DUTY_ON_W = 8;
  localparam int DUTY_OFF_W = 12;
  localparam int DUTY_ON_MAX_MS = 256;
  localparam int DUTY_PRESCALE =
    SLOW_OSC_HZ * DUTY_ON_MAX_MS / 1000 / (1 << DUTY_ON_W);
  localparam int PERIODIC_WAKE_TIMER_W = 16;
  localparam int PERIODIC_WAKE_TIMER_PRE_W = 9;
  localparam int PERIODIC_WAKE_TIMER_DIV_FAST = 8;
  localparam int PERIODIC_WAKE_TIMER_DIV_SLOW = 512;
  localparam logic [PERIODIC_WAKE_TIMER_W-1:0] PERIODIC_WAKE_TIMER_RELOAD = 16'hffff;
  localparam int RESET_HOLD_CYCLES = 16;
  localparam int INIT_W = 5;
  localparam int STRAP_SETTLE = 2;
  localparam int GPIO_WAKE_N = 6;

  // Register map (byte addresses)
  localparam int AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_WAKE_CAUSE = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_WAKE_TIMER = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] REG_DUTY_CFG = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields
  localparam int CTRL_IDLE_CMD = 0;
  localparam int CTRL_PDWN_CMD = 1;
  localparam int CTRL_SWRST_CMD = 2;
  localparam int CTRL_TSHDWN_EN = 3;
  localparam int CTRL_PERIODIC_WAKE_TIMER_DIVSEL = 4;
  localparam int CTRL_RX_LP_MODE = 5;
  localparam int CTRL_RX_WAKE_EN = 6;
  localparam int CTRL_RX_KEEP = 7;
  localparam int CTRL_MASK_LSB = 8;
  localparam int CTRL_GPIO_EN_LSB = 16;
  localparam logic [31:0] CTRL_STORE_MASK = 32'h003f_0ff8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Wake sources, bit positions in cause field; mask field holds all but WK_TEMP
  localparam int WK_TIMER = 0;
  localparam int WK_CARRIER = 1;
  localparam int WK_IDMATCH = 2;
  localparam int WK_GPIO = 3;
  localparam int WK_TEMP = 4;
  localparam int WK_N = 5;

  // Duty-cycle configuration fields and reset values
  localparam int DUTY_ON_LSB = 0;
  localparam int DUTY_OFF_LSB = 8;
  localparam logic [31:0] DUTY_RESET = 32'h000f_ff3f;

  // Status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_MODE_VALID = 6;
  localparam int ST_TEMP_GOOD = 7;
  localparam int ST_RX_ON = 8;

  typedef enum logic [1:0] {
    MODE_RESERVED = 2'h0,
    MODE_DEBUG = 2'h1,
    MODE_PROGRAM = 2'h2,
    MODE_NORMAL = 2'h3
  } wpsc_mode_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_RUN = 3'h1,
    ST_IDLE = 3'h3,
    ST_PDWN = 3'h2,
    ST_SHDN = 3'h6
  } wpsc_state_t;

  typedef struct packed {
    logic sysCtrlSupply;
    logic cpuSupply;
    logic cpuClkEn;
    logic periphSupply;
    logic regSupply;
    logic iramSupply;
    logic memSupply;
    logic hfOscSupply;
    logic xramActive;
    logic lowBattActive;
    logic tmaxActive;
    logic rxSupply;
    logic rxActive;
  } wpsc_pwr_t;

endpackage : wpsc_pkg

// file: wpsc_sys_partner.sv
// Purpose: CPU-side model raising a peripheral interrupt in idle
// Assumes: irqReq comes from the bench
// Notes: drops the interrupt once the CPU clock runs again
`timescale 1ns/10ps
module wpsc_sys_partner #(
  parameter int DLY = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Request and core clock state
  input wire logic irqReq,
  input wire logic cpuClkEn,
  // Interrupt out
  output logic periphIrq
);
  logic [3:0] cnt_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 4'h0;
      periphIrq <= 1'b0;
    end else if (cpuClkEn) begin
      cnt_reg <= 4'h0;
      periphIrq <= 1'b0;
    end else if (irqReq) begin
      cnt_reg <= cnt_reg + 4'h1;
      periphIrq <= (cnt_reg >= 4'(DLY));
    end
  end
endmodule : wpsc_sys_partner

// file: wpsc_wakeup_ctrl.sv
// Purpose: always-on wake-up, reset and power-state controller
// Assumes: resetn is the power-on / brown-out reset; pins are asynchronous
// Notes: AXI4-Lite register slave; one write and one read in flight
`timescale 1ns/10ps
module wpsc_wakeup_ctrl
  import wpsc_pkg::*;
#(
  parameter int TICK_CYCLES = SLOW_TICK_CYCLES
) (
  // Clock and power-on / brown-out reset
  input wire logic mclk,
  input wire logic resetn,
  // AXI4-Lite write channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and wake sources, asynchronous
  input wire logic modeStrapLow,
  input wire logic modeStrapHigh,
  input wire logic [GPIO_WAKE_N-1:0] gpioPin,
  input wire logic rxCarrierDet,
  input wire logic rxIdMatch,
  input wire logic overtempGood,
  // System side
  input wire logic periphIrq,
  output logic sysResetN,
  output logic bootLoad,
  output wpsc_mode_t opMode,
  output wpsc_pwr_t pwrCtl
);

  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam int SYNC_W = GPIO_WAKE_N + 5;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [SYNC_W-1:0] syncA_reg;
  logic [SYNC_W-1:0] syncB_reg;
  wire [SYNC_W-1:0] asyncIn = {overtempGood, rxIdMatch, rxCarrierDet,
                               gpioPin, modeStrapHigh, modeStrapLow};
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      syncA_reg <= '1;
      syncB_reg <= '1;
    end else begin
      syncA_reg <= asyncIn;
      syncB_reg <= syncA_reg;
    end
  end
  wire [1:0] strapSync = syncB_reg[1:0];
  wire [GPIO_WAKE_N-1:0] gpioSync = syncB_reg[GPIO_WAKE_N+1:2];
  wire carrierSync = syncB_reg[GPIO_WAKE_N+2];
  wire idMatchSync = syncB_reg[GPIO_WAKE_N+3];
  wire tempGoodSync = syncB_reg[GPIO_WAKE_N+4];

  ////////////////////////////////////////////////////////////////////////////
  // Mode latch after power-on release
  logic [1:0] strapCnt_reg;
  logic modeValid_reg;
  wpsc_mode_t opMode_reg;
  wire strapReady = strapCnt_reg == 2'(STRAP_SETTLE);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strapCnt_reg <= 2'h0;
      modeValid_reg <= 1'b0;
      opMode_reg <= MODE_RESERVED;
    end else if (!modeValid_reg) begin
      strapCnt_reg <= strapReady ? strapCnt_reg : strapCnt_reg + 2'h1;
      modeValid_reg <= strapReady;
      if (strapReady) opMode_reg <= wpsc_mode_t'(strapSync);
    end
  end
  assign opMode = opMode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // 4 kHz tick and periodic wake timer
  logic [TICK_W-1:0] tickCnt_reg;
  logic [PERIODIC_WAKE_TIMER_PRE_W-1:0] pwdtPre_reg;
  logic [PERIODIC_WAKE_TIMER_W-1:0] pwdtCnt_reg;
  logic [31:0] ctrl_reg;
  wire slowTick = tickCnt_reg == TICK_W'(TICK_CYCLES - 1);
  wire [PERIODIC_WAKE_TIMER_PRE_W-1:0] pwdtPreTop = ctrl_reg[CTRL_PERIODIC_WAKE_TIMER_DIVSEL] ?
    PERIODIC_WAKE_TIMER_PRE_W'(PERIODIC_WAKE_TIMER_DIV_SLOW - 1) : PERIODIC_WAKE_TIMER_PRE_W'(PERIODIC_WAKE_TIMER_DIV_FAST - 1);
  wire pwdtTick = slowTick && pwdtPre_reg >= pwdtPreTop;
  wire pwdtUnder = pwdtTick && pwdtCnt_reg == '0;
  logic pwdtLoad;
  logic [31:0] wrMerged;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tickCnt_reg <= '0;
      pwdtPre_reg <= '0;
      pwdtCnt_reg <= PERIODIC_WAKE_TIMER_RELOAD;
    end else begin
      tickCnt_reg <= slowTick ? '0 : tickCnt_reg + TICK_W'(1);
      if (slowTick) pwdtPre_reg <= pwdtTick ? '0 : pwdtPre_reg + 9'h1;
      if (pwdtLoad) pwdtCnt_reg <= wrMerged[PERIODIC_WAKE_TIMER_W-1:0];
      else if (pwdtUnder) pwdtCnt_reg <= PERIODIC_WAKE_TIMER_RELOAD;
      else if (pwdtTick) pwdtCnt_reg <= pwdtCnt_reg - 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver on/off duty cycle
  logic [31:0] duty_reg;
  logic [DUTY_ON_W-1:0] onCnt_reg;
  logic [DUTY_OFF_W-1:0] offCnt_reg;
  logic [1:0] dutyPre_reg;
  logic rxOn_reg;
  wpsc_state_t state_reg;
  wire lowPwrState = state_reg == ST_PDWN || state_reg == ST_SHDN;
  wire [DUTY_ON_W-1:0] onPeriod = duty_reg[DUTY_ON_LSB +: DUTY_ON_W];
  wire [DUTY_OFF_W-1:0] offPeriod = duty_reg[DUTY_OFF_LSB +: DUTY_OFF_W];
  wire dutyRun = ctrl_reg[CTRL_RX_LP_MODE] && ctrl_reg[CTRL_RX_WAKE_EN] &&
                 (!lowPwrState || ctrl_reg[CTRL_RX_KEEP]);
  wire dutyTick = slowTick && dutyPre_reg == 2'(DUTY_PRESCALE - 1);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dutyPre_reg <= 2'h0;
      rxOn_reg <= 1'b1;
      onCnt_reg <= '0;
      offCnt_reg <= '0;
    end else if (!dutyRun) begin
      dutyPre_reg <= 2'h0;
      rxOn_reg <= 1'b1;
      onCnt_reg <= onPeriod;
      offCnt_reg <= offPeriod;
    end else if (slowTick) begin
      dutyPre_reg <= dutyPre_reg + 2'h1;
      if (dutyTick && rxOn_reg) begin
        if (onCnt_reg == '0) rxOn_reg <= 1'b0;
        onCnt_reg <= onCnt_reg == '0 ? onPeriod : onCnt_reg - 8'h1;
      end else if (dutyTick) begin
        if (offCnt_reg == '0) rxOn_reg <= 1'b1;
        offCnt_reg <= offCnt_reg == '0 ? offPeriod : offCnt_reg - 12'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  logic awFull_reg, wFull_reg, bvalid_reg, arDone_reg;
  logic [AXI_ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg, rdata_reg, cause_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] byteMask, wrOld;
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign byteMask[8*lane +: 8] = {8{wStrb_reg[lane]}};
    end
  endgenerate
  wire [AXI_ADDR_W-1:0] wAddr = {awAddr_reg[AXI_ADDR_W-1:2], 2'b00};
  wire doWrite = awFull_reg && wFull_reg && !bvalid_reg;
  wire wrCtrl = doWrite && wAddr == REG_CTRL;
  wire wrCause = doWrite && wAddr == REG_WAKE_CAUSE;
  wire wrDuty = doWrite && wAddr == REG_DUTY_CFG;
  wire wrMapped = wrCtrl || wrCause || wrDuty || wAddr == REG_STATUS ||
                  wAddr == REG_WAKE_TIMER;
  assign pwdtLoad = doWrite && wAddr == REG_WAKE_TIMER;
  assign wrOld = wAddr == REG_DUTY_CFG ? duty_reg : ctrl_reg;
  assign wrMerged = (wData_reg & byteMask) | (wrOld & ~byteMask);
  wire [31:0] cmdBits = wrCtrl ? wData_reg & byteMask : 32'h0;
  assign s_axi_awready = !awFull_reg && !bvalid_reg;
  assign s_axi_wready = !wFull_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awFull_reg <= 1'b0;
      wFull_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awFull_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (doWrite) awFull_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        wFull_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (doWrite) wFull_reg <= 1'b0;
      if (doWrite) bresp_reg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      bvalid_reg <= doWrite || (bvalid_reg && !s_axi_bready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored registers; the wake-cause set wins over a clear
  logic [WK_N-1:0] causeSet;
  wire [31:0] clrBits = wData_reg & byteMask;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RESET;
      duty_reg <= DUTY_RESET;
      cause_reg <= '0;
    end else begin
      if (wrCtrl) ctrl_reg <= wrMerged & CTRL_STORE_MASK;
      if (wrDuty) duty_reg <= {12'h0, wrMerged[19:0]};
      cause_reg <= (cause_reg & ~(wrCause ? clrBits : 32'h0)) |
                   {27'h0, causeSet};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path; duty counters have no read path
  wire [AXI_ADDR_W-1:0] rAddr = {s_axi_araddr[AXI_ADDR_W-1:2], 2'b00};
  wire [31:0] statusWord = {23'h0, rxOn_reg, tempGoodSync, modeValid_reg,
                            opMode_reg, 1'b0, state_reg};
  wire rdMapped = rAddr == REG_CTRL || rAddr == REG_STATUS ||
                  rAddr == REG_WAKE_CAUSE || rAddr == REG_WAKE_TIMER ||
                  rAddr == REG_DUTY_CFG;
  wire [31:0] readData =
    rAddr == REG_CTRL ? ctrl_reg :
    rAddr == REG_STATUS ? statusWord :
    rAddr == REG_WAKE_CAUSE ? cause_reg :
    rAddr == REG_WAKE_TIMER ? {16'h0, pwdtCnt_reg} :
    rAddr == REG_DUTY_CFG ? duty_reg : 32'h0;
  assign s_axi_arready = !arDone_reg;
  assign s_axi_rvalid = arDone_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arDone_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && !arDone_reg) begin
      arDone_reg <= 1'b1;
      rdata_reg <= readData;
      rresp_reg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) arDone_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake sources and power-state machine
  wire [WK_N-2:0] wakeMask = ctrl_reg[CTRL_MASK_LSB +: WK_N-1];
  wire [GPIO_WAKE_N-1:0] gpioEn =
    ctrl_reg[CTRL_GPIO_EN_LSB +: GPIO_WAKE_N];
  wire gpioWake = |(~gpioSync & gpioEn);
  wire [WK_N-2:0] wakeRaw = {gpioWake, idMatchSync, carrierSync, pwdtUnder};
  wire [WK_N-2:0] wakeLive = wakeRaw & ~wakeMask;
  wire anyWake = |wakeLive;
  wire tempExit = state_reg == ST_SHDN && tempGoodSync;
  wire idleCmd = cmdBits[CTRL_IDLE_CMD];
  wire pdwnCmd = cmdBits[CTRL_PDWN_CMD];
  wire swRstCmd = cmdBits[CTRL_SWRST_CMD];
  assign causeSet = {tempExit, state_reg == ST_PDWN ? wakeLive[3:1] : 3'h0,
                     pwdtUnder};

  logic [INIT_W-1:0] initCnt_reg;
  logic rstHold_reg, sysResetN_reg, bootLoad_reg;
  wire holdDone = initCnt_reg == INIT_W'(RESET_HOLD_CYCLES);
  wire initDone = state_reg == ST_INIT && holdDone && modeValid_reg;
  wpsc_state_t stateNext;
  logic rstEntry;
  always_comb begin
    stateNext = state_reg;
    rstEntry = 1'b0;
    case (state_reg)
      ST_INIT: begin
        if (initDone) stateNext = ST_RUN;
      end
      ST_RUN: begin
        if (swRstCmd || pwdtUnder) begin
          stateNext = ST_INIT;
          rstEntry = 1'b1;
        end else if (pdwnCmd) begin
          stateNext = ctrl_reg[CTRL_TSHDWN_EN] && !tempGoodSync ?
                      ST_SHDN : ST_PDWN;
        end else if (idleCmd) stateNext = ST_IDLE;
      end
      ST_IDLE: begin
        if (pwdtUnder) begin
          stateNext = ST_INIT;
          rstEntry = 1'b1;
        end else if (periphIrq) stateNext = ST_RUN;
      end
      ST_PDWN: begin
        if (anyWake) begin
          stateNext = ST_INIT;
          rstEntry = wakeLive[WK_TIMER];
        end
      end
      ST_SHDN: begin
        if (tempGoodSync) begin
          stateNext = ST_INIT;
          rstEntry = 1'b1;
        end
      end
      default: begin
        stateNext = ST_INIT;
        rstEntry = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_INIT;
      initCnt_reg <= '0;
      rstHold_reg <= 1'b1;
      sysResetN_reg <= 1'b0;
      bootLoad_reg <= 1'b0;
    end else begin
      state_reg <= stateNext;
      if (state_reg != ST_INIT) begin
        initCnt_reg <= '0;
        rstHold_reg <= rstEntry;
      end else if (!holdDone) initCnt_reg <= initCnt_reg + 5'h1;
      sysResetN_reg <= !(state_reg == ST_INIT && rstHold_reg && !holdDone);
      bootLoad_reg <= initDone;
    end
  end
  assign sysResetN = sysResetN_reg;
  assign bootLoad = bootLoad_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Power gating per state
  wpsc_pwr_t pwrNext, pwr_reg;
  always_comb begin
    pwrNext = '0;
    if (!lowPwrState) begin
      pwrNext = '1;
      pwrNext.cpuClkEn = state_reg != ST_IDLE;
      pwrNext.tmaxActive = ctrl_reg[CTRL_TSHDWN_EN];
      pwrNext.rxActive = !dutyRun || rxOn_reg;
    end else begin
      pwrNext.rxSupply = ctrl_reg[CTRL_RX_KEEP];
      pwrNext.rxActive = ctrl_reg[CTRL_RX_KEEP] && (!dutyRun || rxOn_reg);
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) pwr_reg <= '1;
    else pwr_reg <= pwrNext;
  end
  assign pwrCtl = pwr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  modeLatch_a: assert property ($rose(modeValid_reg) |->
    opMode_reg == wpsc_mode_t'($past(strapSync)))
    else $error("mode not latched from straps");
  modeKept_a: assert property (modeValid_reg && $past(modeValid_reg) |->
    $stable(opMode_reg))
    else $error("latched mode changed");
  initReset_a: assert property (state_reg == ST_RUN && swRstCmd |=>
    state_reg == ST_INIT ##1 !sysResetN)
    else $error("software reset did not reach init");
  idleClock_a: assert property (state_reg == ST_IDLE |=>
    state_reg != ST_IDLE || !pwrCtl.cpuClkEn)
    else $error("cpu clock running in idle");
  idleExit_a: assert property (state_reg == ST_IDLE && periphIrq &&
    !pwdtUnder |=> state_reg == ST_RUN)
    else $error("interrupt did not resume run");
  shdnHold_a: assert property (state_reg == ST_SHDN && !tempGoodSync |=>
    state_reg == ST_SHDN)
    else $error("left shutdown while hot");
  shdnExit_a: assert property (state_reg == ST_SHDN && tempGoodSync |=>
    state_reg == ST_INIT ##1 !sysResetN ##1 !sysResetN)
    else $error("shutdown exit without reset");
  pdwnPower_a: assert property (lowPwrState ##1 lowPwrState |->
    !pwrCtl.cpuSupply && !pwrCtl.regSupply && !pwrCtl.iramSupply &&
    !pwrCtl.xramActive && !pwrCtl.sysCtrlSupply)
    else $error("supply left on in low power");
  maskedWake_a: assert property (state_reg == ST_PDWN && !anyWake |=>
    state_reg == ST_PDWN ##1 !pwrCtl.sysCtrlSupply)
    else $error("masked wake left powerdown");
  wakeHand_a: assert property (state_reg == ST_PDWN && anyWake |=>
    state_reg == ST_INIT ##1 pwrCtl.sysCtrlSupply)
    else $error("wake did not power controller");
  bootRun_a: assert property (bootLoad |-> state_reg == ST_RUN &&
    $past(state_reg) == ST_INIT)
    else $error("boot load outside init exit");
  pwdtReload_a: assert property (pwdtUnder && !pwdtLoad |=>
    pwdtCnt_reg == 16'hffff)
    else $error("wake timer not reloaded");
  dutyIdle_a: assert property (!dutyRun |=> rxOn_reg)
    else $error("duty timer ran while disabled");

endmodule : wpsc_wakeup_ctrl
